/* hw/tmr0_regs.vh */
`ifndef TMR0_REGS_VH
`define TMR0_REGS_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define TMR0_IDX_CMP_B      6'h15
`define TMR0_IDX_CMP_A      6'h16
`define TMR0_IDX_COUNTER    6'h17
`define TMR0_IDX_CTL_B      6'h18
`define TMR0_IDX_CTL_A      6'h19
`define TMR0_IDX_FLAGS      6'h25
`define TMR0_IDX_ENABLES    6'h26

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TMR0_CTLB_FORCE_A   7
`define TMR0_CTLB_FORCE_B   6
`define TMR0_CTLB_WGM2      3
`define TMR0_CTLA_OMODE_A_HI 7
`define TMR0_CTLA_OMODE_A_LO 6
`define TMR0_CTLA_OMODE_B_HI 5
`define TMR0_CTLA_OMODE_B_LO 4
`define TMR0_BIT_MATCH_B    2
`define TMR0_BIT_MATCH_A    1
`define TMR0_BIT_OVERFLOW   0
`define TMR0_IRQ_RSVD_MASK  8'hbf
`define TMR0_CTLA_MASK      8'hf3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TMR0_RST_BYTE       8'h00
`define TMR0_RST_CTLB       4'h0

// ----------------------------------------------------------------
// clock select and waveform mode codes
// ----------------------------------------------------------------
`define TMR0_CS_STOP        3'h0
`define TMR0_CS_DIV1        3'h1
`define TMR0_CS_DIV8        3'h2
`define TMR0_CS_DIV64       3'h3
`define TMR0_CS_DIV256      3'h4
`define TMR0_CS_DIV1024     3'h5
`define TMR0_CS_EXT_FALL    3'h6
`define TMR0_CS_EXT_RISE    3'h7
`define TMR0_WGM_CTC        3'h2
`define TMR0_WGM_PC_TOPA    3'h5
`define TMR0_WGM_FAST_TOPA  3'h7
`define TMR0_MAX            8'hff
`define TMR0_BOTTOM         8'h00

// ----------------------------------------------------------------
// prescaler tap masks
// ----------------------------------------------------------------
`define TMR0_PRE_W          10
`define TMR0_TAP8           10'h007
`define TMR0_TAP64          10'h03f
`define TMR0_TAP256         10'h0ff
`define TMR0_TAP1024        10'h3ff

// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define TMR0_RESP_OKAY      2'h0
`define TMR0_RESP_SLVERR    2'h2

`endif

/* hw/tmr0_core.v */
`timescale 1ns/1ns
`include "tmr0_regs.vh"

module tmr0_core (
	// clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// axi4-lite write address
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	// axi4-lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	// axi4-lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// axi4-lite read address
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	// axi4-lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// cpu interrupt side
	input  wire        cpu_global_irq_enable,
	input  wire        vector_ack_match_a,
	input  wire        vector_ack_match_b,
	input  wire        vector_ack_overflow,
	output wire        irq_match_a,
	output wire        irq_match_b,
	output wire        irq_overflow,
	output wire        irq,
	// pins
	input  wire        ext_count_pin,
	output reg         wave_out_a,
	output wire        wave_oe_a,
	output reg         wave_out_b,
	output wire        wave_oe_b
);

// ----------------------------------------------------------------
// state
// ----------------------------------------------------------------
reg  [7:0]              counter_value_r;
reg  [7:0]              counter_value_nxt;
reg  [7:0]              compare_a_value_r;
reg  [7:0]              compare_b_value_r;
reg  [7:0]              timer_control_a_r;
reg  [3:0]              timer_control_b_r;
reg  [7:0]              timer_interrupt_flags_r;
reg  [7:0]              timer_interrupt_flags_nxt;
reg  [7:0]              timer_interrupt_enables_r;
reg                     count_down_r;
reg                     count_down_nxt;
reg                     match_block_r;
reg  [`TMR0_PRE_W-1:0]  prescale_r;
reg  [2:0]              ext_sync_r;
reg                     wave_a_nxt;
reg                     wave_b_nxt;
reg                     tick;
reg  [7:0]              rd_val;
reg                     rd_hit;
reg                     wr_hit;

// ----------------------------------------------------------------
// mode decode
// ----------------------------------------------------------------
wire [2:0] waveform_mode      = {timer_control_b_r[`TMR0_CTLB_WGM2],
                                 timer_control_a_r[1:0]};
wire       waveform_mode_high_bit = timer_control_b_r[`TMR0_CTLB_WGM2];
wire [2:0] clock_select_field = timer_control_b_r[2:0];
wire [1:0] out_mode_a = timer_control_a_r[`TMR0_CTLA_OMODE_A_HI:
                                          `TMR0_CTLA_OMODE_A_LO];
wire [1:0] out_mode_b = timer_control_a_r[`TMR0_CTLA_OMODE_B_HI:
                                          `TMR0_CTLA_OMODE_B_LO];
// odd mode codes are the pwm ones; 4 and 6 run as normal
wire       is_pwm   = waveform_mode[0];
wire       is_phase = waveform_mode[0] & ~waveform_mode[1];
wire       top_is_a = (waveform_mode == `TMR0_WGM_CTC) |
                      (waveform_mode == `TMR0_WGM_PC_TOPA) |
                      (waveform_mode == `TMR0_WGM_FAST_TOPA);
wire [7:0] top_val  = top_is_a ? compare_a_value_r : `TMR0_MAX;
wire       at_top   = (counter_value_r == top_val);
wire       at_max   = (counter_value_r == `TMR0_MAX);
wire       at_bot   = (counter_value_r == `TMR0_BOTTOM);

// ----------------------------------------------------------------
// bus decode
// ----------------------------------------------------------------
wire       wr_fire = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
wire       wr_en   = wr_fire & s_axi_wstrb[0];
wire [5:0] wr_idx  = s_axi_awaddr[7:2];
wire [5:0] rd_idx  = s_axi_araddr[7:2];
wire [7:0] wr_byte = s_axi_wdata[7:0];
wire       rd_fire = s_axi_arvalid & ~s_axi_rvalid;

// address and data are taken together, so neither can slip ahead
assign s_axi_awready = wr_fire;
assign s_axi_wready  = wr_fire;
assign s_axi_arready = ~s_axi_rvalid;

wire wr_cnt  = wr_en & (wr_idx == `TMR0_IDX_COUNTER);
wire wr_cmpa = wr_en & (wr_idx == `TMR0_IDX_CMP_A);
wire wr_cmpb = wr_en & (wr_idx == `TMR0_IDX_CMP_B);
wire wr_ctla = wr_en & (wr_idx == `TMR0_IDX_CTL_A);
wire wr_ctlb = wr_en & (wr_idx == `TMR0_IDX_CTL_B);
wire wr_flg  = wr_en & (wr_idx == `TMR0_IDX_FLAGS);
wire wr_msk  = wr_en & (wr_idx == `TMR0_IDX_ENABLES);

always @* begin
	case (wr_idx)
	`TMR0_IDX_CMP_B, `TMR0_IDX_CMP_A, `TMR0_IDX_COUNTER,
	`TMR0_IDX_CTL_B, `TMR0_IDX_CTL_A, `TMR0_IDX_FLAGS,
	`TMR0_IDX_ENABLES: wr_hit = 1'b1;
	default:           wr_hit = 1'b0;
	endcase
end

// ----------------------------------------------------------------
// force strobes
// ----------------------------------------------------------------
// ignored in pwm; software keeps them zero there anyway
wire force_match_a = wr_ctlb & wr_byte[`TMR0_CTLB_FORCE_A] &
                     ~is_pwm;
wire force_match_b = wr_ctlb & wr_byte[`TMR0_CTLB_FORCE_B] &
                     ~is_pwm;

// ----------------------------------------------------------------
// clock source
// ----------------------------------------------------------------
// pin is sampled whatever its direction, so software may drive it
wire ext_rise = ext_sync_r[1] & ~ext_sync_r[2];
wire ext_fall = ~ext_sync_r[1] & ext_sync_r[2];

always @* begin
	case (clock_select_field)
	`TMR0_CS_STOP:     tick = 1'b0;
	`TMR0_CS_DIV1:     tick = 1'b1;
	`TMR0_CS_DIV8:     tick = (prescale_r & `TMR0_TAP8) == `TMR0_TAP8;
	`TMR0_CS_DIV64:    tick = (prescale_r & `TMR0_TAP64) == `TMR0_TAP64;
	`TMR0_CS_DIV256:   tick = (prescale_r & `TMR0_TAP256) == `TMR0_TAP256;
	`TMR0_CS_DIV1024:  tick = (prescale_r & `TMR0_TAP1024) ==
	                          `TMR0_TAP1024;
	`TMR0_CS_EXT_FALL: tick = ext_fall;
	`TMR0_CS_EXT_RISE: tick = ext_rise;
	default:           tick = 1'b0;
	endcase
end

// ----------------------------------------------------------------
// events
// ----------------------------------------------------------------
wire match_a = tick & ~match_block_r &
               (counter_value_r == compare_a_value_r);
wire match_b = tick & ~match_block_r &
               (counter_value_r == compare_b_value_r);
// overflow point differs per mode
wire overflow = tick & (is_phase ? (count_down_r & at_bot) :
                (waveform_mode == `TMR0_WGM_FAST_TOPA) ? at_top :
                at_max);
// fast pwm reaches bottom on the wrap from top
wire fast_wrap = tick & is_pwm & ~is_phase & at_top;

// ----------------------------------------------------------------
// counter
// ----------------------------------------------------------------
always @* begin
	counter_value_nxt = counter_value_r;
	count_down_nxt    = count_down_r;
	if (tick) begin
		if (is_phase) begin
			if (!count_down_r) begin
				if (at_top) begin
					count_down_nxt    = 1'b1;
					counter_value_nxt = counter_value_r - 8'h01;
				end else begin
					counter_value_nxt = counter_value_r + 8'h01;
				end
			end else if (at_bot) begin
				count_down_nxt    = 1'b0;
				counter_value_nxt = counter_value_r + 8'h01;
			end else begin
				counter_value_nxt = counter_value_r - 8'h01;
			end
		end else if (at_top) begin
			// ctc clears on any tick at top, even while the match is blocked, never on a force
			counter_value_nxt = `TMR0_BOTTOM;
		end else begin
			counter_value_nxt = counter_value_r + 8'h01;
		end
	end
	// bus write has priority over counting
	if (wr_cnt)
		counter_value_nxt = wr_byte;
end

// ----------------------------------------------------------------
// flags
// ----------------------------------------------------------------
wire [7:0] flag_set = {5'h00, match_b, match_a, overflow};
wire [7:0] flag_ack = {5'h00, vector_ack_match_b, vector_ack_match_a,
                       vector_ack_overflow};

always @* begin
	timer_interrupt_flags_nxt = timer_interrupt_flags_r & ~flag_ack;
	if (wr_flg)
		timer_interrupt_flags_nxt = timer_interrupt_flags_nxt & ~wr_byte;
	// a new event in the clearing cycle is kept
	timer_interrupt_flags_nxt = (timer_interrupt_flags_nxt | flag_set) &
	                            `TMR0_IRQ_RSVD_MASK;
end

wire [7:0] pending = timer_interrupt_flags_r & timer_interrupt_enables_r;
assign irq_match_b  = cpu_global_irq_enable &
                      pending[`TMR0_BIT_MATCH_B];
assign irq_match_a  = cpu_global_irq_enable &
                      pending[`TMR0_BIT_MATCH_A];
assign irq_overflow = cpu_global_irq_enable &
                      pending[`TMR0_BIT_OVERFLOW];
assign irq = irq_match_a | irq_match_b | irq_overflow;

// ----------------------------------------------------------------
// waveform outputs
// ----------------------------------------------------------------
function wave_f;
	input       cur;
	input [1:0] mode;
	input       hit;
	input       frc;
	input       pwm;
	input       phase;
	input       up;
	input       bot;
	input       tgl_ok;
	begin
		wave_f = cur;
		if (!pwm) begin
			if (hit | frc) begin
				case (mode)
				2'h1:    wave_f = ~cur;
				2'h2:    wave_f = 1'b0;
				2'h3:    wave_f = 1'b1;
				default: wave_f = cur;
				endcase
			end
		end else if (mode[1]) begin
			if (phase) begin
				if (hit)
					wave_f = mode[0] ^ ~up;
			end else if (hit) begin
				wave_f = mode[0];
			end else if (bot) begin
				wave_f = ~mode[0];
			end
		end else if (mode[0] & tgl_ok & hit) begin
			wave_f = ~cur;
		end
	end
endfunction

always @* begin
	wave_a_nxt = wave_f(wave_out_a, out_mode_a, match_a, force_match_a,
	                    is_pwm, is_phase, ~count_down_r, fast_wrap,
	                    waveform_mode_high_bit);
	wave_b_nxt = wave_f(wave_out_b, out_mode_b, match_b, force_match_b,
	                    is_pwm, is_phase, ~count_down_r, fast_wrap,
	                    1'b0);
end

assign wave_oe_a = |out_mode_a;
assign wave_oe_b = |out_mode_b;

// ----------------------------------------------------------------
// read mux
// ----------------------------------------------------------------
always @* begin
	rd_hit = 1'b1;
	case (rd_idx)
	`TMR0_IDX_CMP_B:   rd_val = compare_b_value_r;
	`TMR0_IDX_CMP_A:   rd_val = compare_a_value_r;
	`TMR0_IDX_COUNTER: rd_val = counter_value_r;
	`TMR0_IDX_CTL_A:   rd_val = timer_control_a_r;
	`TMR0_IDX_CTL_B:   rd_val = {4'h0, timer_control_b_r};
	`TMR0_IDX_FLAGS:   rd_val = timer_interrupt_flags_r &
	                            `TMR0_IRQ_RSVD_MASK;
	`TMR0_IDX_ENABLES: rd_val = timer_interrupt_enables_r &
	                            `TMR0_IRQ_RSVD_MASK;
	default: begin
		rd_val = `TMR0_RST_BYTE;
		rd_hit = 1'b0;
	end
	endcase
end

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
always @(posedge aclk) begin
	if (!aresetn) begin
		counter_value_r           <= `TMR0_RST_BYTE;
		compare_a_value_r         <= `TMR0_RST_BYTE;
		compare_b_value_r         <= `TMR0_RST_BYTE;
		timer_control_a_r         <= `TMR0_RST_BYTE;
		timer_control_b_r         <= `TMR0_RST_CTLB;
		timer_interrupt_flags_r   <= `TMR0_RST_BYTE;
		timer_interrupt_enables_r <= `TMR0_RST_BYTE;
		count_down_r              <= 1'b0;
		match_block_r             <= 1'b0;
		prescale_r                <= {`TMR0_PRE_W{1'b0}};
		ext_sync_r                <= 3'h0;
		wave_out_a                <= 1'b0;
		wave_out_b                <= 1'b0;
		s_axi_bvalid              <= 1'b0;
		s_axi_bresp               <= `TMR0_RESP_OKAY;
		s_axi_rvalid              <= 1'b0;
		s_axi_rresp               <= `TMR0_RESP_OKAY;
		s_axi_rdata               <= 32'h00000000;
	end else begin
		prescale_r              <= prescale_r + {{(`TMR0_PRE_W-1){1'b0}}, 1'b1};
		ext_sync_r              <= {ext_sync_r[1:0], ext_count_pin};
		counter_value_r         <= counter_value_nxt;
		count_down_r            <= count_down_nxt;
		timer_interrupt_flags_r <= timer_interrupt_flags_nxt;
		wave_out_a              <= wave_a_nxt;
		wave_out_b              <= wave_b_nxt;
		// block lasts until the first tick after the write
		if (wr_cnt)
			match_block_r <= 1'b1;
		else if (tick)
			match_block_r <= 1'b0;
		if (wr_cmpa)
			compare_a_value_r <= wr_byte;
		if (wr_cmpb)
			compare_b_value_r <= wr_byte;
		if (wr_ctla)
			timer_control_a_r <= wr_byte & `TMR0_CTLA_MASK;
		if (wr_ctlb)
			timer_control_b_r <= wr_byte[3:0];
		if (wr_msk)
			timer_interrupt_enables_r <= wr_byte &
			                             `TMR0_IRQ_RSVD_MASK;
		if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? `TMR0_RESP_OKAY : `TMR0_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
		if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h000000, rd_val};
			s_axi_rresp  <= rd_hit ? `TMR0_RESP_OKAY : `TMR0_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
end

endmodule

/* verif/tmr0_assertions.sv */
`timescale 1ns/1ns
`include "tmr0_regs.vh"
module tmr0_chk (
	// clock and reset
	input wire        aclk,
	input wire        aresetn,
	// register bus
	input wire        s_axi_awvalid,
	input wire        s_axi_wvalid,
	input wire        s_axi_awready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire [7:0]  s_axi_araddr,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0]  s_axi_rresp,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	// interrupts and pins
	input wire        cpu_global_irq_enable,
	input wire        irq_match_a,
	input wire        irq_match_b,
	input wire        irq_overflow,
	input wire        irq,
	input wire        wave_out_a
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire       rd_go = s_axi_arvalid && s_axi_arready;
	wire [5:0] ri    = s_axi_araddr[7:2];

	property p_irq_or;
		irq == (irq_match_a | irq_match_b | irq_overflow);
	endproperty
	a_irq_or: assert property (p_irq_or)
		else $error("irq is not the or of its sources");
	property p_no_glob;
		!cpu_global_irq_enable |-> !irq;
	endproperty
	a_no_glob: assert property (p_no_glob)
		else $error("irq raised without global enable");
	property p_wr_resp;
		s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid;
	endproperty
	a_wr_resp: assert property (p_wr_resp)
		else $error("write taken without response");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped early");
	property p_rd_resp;
		rd_go |=> s_axi_rvalid;
	endproperty
	a_rd_resp: assert property (p_rd_resp)
		else $error("read taken without data");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read data dropped early");
	property p_force_rd0;
		rd_go && ri == `TMR0_IDX_CTL_B |=> s_axi_rdata[7:6] == 2'b00;
	endproperty
	a_force_rd0: assert property (p_force_rd0)
		else $error("force bits read nonzero");
	property p_rsvd_rd0;
		rd_go && (ri == `TMR0_IDX_FLAGS || ri == `TMR0_IDX_ENABLES)
			|=> s_axi_rdata[6] == 1'b0;
	endproperty
	a_rsvd_rd0: assert property (p_rsvd_rd0)
		else $error("reserved bit read nonzero");
	property p_unmapped;
		rd_go && ri < 6'h15 |=> s_axi_rresp == `TMR0_RESP_SLVERR;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not refused");
	c_wr: cover property (s_axi_awvalid && s_axi_awready);
	c_irq: cover property ($rose(irq));
	c_wave: cover property ($rose(wave_out_a));
endmodule

/* verif/tmr0_core_bench.sv */
`timescale 1ns/1ns
`include "tmr0_regs.vh"
module tmr0_core_bench;
	reg         aclk = 0, aresetn = 0;
	reg  [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
	reg  [31:0] s_axi_wdata = 0;
	reg  [3:0]  s_axi_wstrb = 4'hf;
	reg         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	reg         s_axi_arvalid = 0, s_axi_rready = 0;
	reg         cpu_global_irq_enable = 0, ext_count_pin = 0;
	reg         vector_ack_match_a = 0, vector_ack_match_b = 0;
	reg         vector_ack_overflow = 0;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire        s_axi_arready, s_axi_rvalid;
	wire [1:0]  s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire        irq_match_a, irq_match_b, irq_overflow, irq;
	wire        wave_out_a, wave_oe_a, wave_out_b, wave_oe_b;
	integer     bad_count = 0, n_tests = 0, cycles = 0, k;
	reg  [7:0]  v, d;
	reg  [1:0]  r;

	tmr0_core DUT (.*);
	always #10 aclk = ~aclk;

	// ----------------------------------------
	// bus and check helpers
	// ----------------------------------------
	task chk(input [31:0] seen, input [31:0] exp, input [63:0] w);
		begin
			n_tests = n_tests + 1;
			if (seen !== exp) begin
				bad_count = bad_count + 1;
				$display("wrong value %0s exp %h seen %h", w, exp, seen);
			end
		end
	endtask
	task wr(input [5:0] i, input [7:0] dd);
		begin
			@(posedge aclk);
			s_axi_awaddr <= {i, 2'b00};
			s_axi_wdata <= {24'h0, dd};
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			do @(posedge aclk);
			while (s_axi_awready !== 1'b1 || s_axi_wready !== 1'b1);
			s_axi_awvalid <= 1'b0;
			s_axi_wvalid <= 1'b0;
			while (s_axi_bvalid !== 1'b1) @(posedge aclk);
			r = s_axi_bresp;
			s_axi_bready <= 1'b0;
		end
	endtask
	task rd(input [5:0] i);
		begin
			@(posedge aclk);
			s_axi_araddr <= {i, 2'b00};
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			do @(posedge aclk); while (s_axi_arready !== 1'b1);
			s_axi_arvalid <= 1'b0;
			while (s_axi_rvalid !== 1'b1) @(posedge aclk);
			d = s_axi_rdata[7:0];
			r = s_axi_rresp;
			s_axi_rready <= 1'b0;
		end
	endtask
	task rdc(input [5:0] i, input [7:0] e);
		begin
			rd(i);
			chk(d, e, "rdata");
		end
	endtask
	task pins(input integer n);
		repeat (n) begin
			@(posedge aclk) ext_count_pin <= 1'b1;
			repeat (4) @(posedge aclk);
			ext_count_pin <= 1'b0;
			repeat (4) @(posedge aclk);
		end
	endtask
	function integer divf(input integer cs);
		divf = (cs == 2) ? 8 : (cs == 3) ? 64 : (cs == 4) ? 256 : 1024;
	endfunction
	task test_done;
		begin
			$display("checks %0d mismatches %0d", n_tests, bad_count);
			if (bad_count == 0 && n_tests > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask

	// ----------------------------------------
	// hang guard, about three times the expected run
	// ----------------------------------------
	always @(posedge aclk) begin
		cycles = cycles + 1;
		if (cycles == 40000) begin
			bad_count = bad_count + 1;
			test_done;
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		v = $urandom(47123);
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		for (k = 'h15; k <= 'h19; k = k + 1)
			rdc(k[5:0], 8'h00);
		rdc(`TMR0_IDX_FLAGS, 8'h00);
		rd(6'h00);
		chk(r, `TMR0_RESP_SLVERR, "rresp");
		wr(6'h00, 8'hff);
		chk(r, `TMR0_RESP_SLVERR, "bresp");
		wr(`TMR0_IDX_ENABLES, 8'hff);
		chk(r, `TMR0_RESP_OKAY, "bresp");
		rdc(`TMR0_IDX_ENABLES, 8'hbf);
		wr(`TMR0_IDX_FLAGS, 8'hff);
		rdc(`TMR0_IDX_FLAGS, 8'h00);
		$display("test regs done");
		v = $urandom % 128;
		wr(`TMR0_IDX_COUNTER, v);
		wr(`TMR0_IDX_CMP_A, v + 8'd3);
		wr(`TMR0_IDX_CMP_B, v + 8'd5);
		rdc(`TMR0_IDX_COUNTER, v);
		wr(`TMR0_IDX_CTL_B, 8'h01);
		repeat (20) @(posedge aclk);
		wr(`TMR0_IDX_CTL_B, 8'h00);
		rdc(`TMR0_IDX_FLAGS, 8'h06);
		wr(`TMR0_IDX_ENABLES, 8'h06);
		chk(irq, 1'b0, "irq");
		@(posedge aclk) cpu_global_irq_enable <= 1'b1;
		@(posedge aclk);
		chk({irq, irq_match_a, irq_match_b, irq_overflow}, 4'he, "irqs");
		@(posedge aclk) vector_ack_match_b <= 1'b1;
		@(posedge aclk) vector_ack_match_b <= 1'b0;
		rdc(`TMR0_IDX_FLAGS, 8'h02);
		@(posedge aclk) vector_ack_match_a <= 1'b1;
		@(posedge aclk) vector_ack_match_a <= 1'b0;
		rdc(`TMR0_IDX_FLAGS, 8'h00);
		chk(irq, 1'b0, "irq");
		$display("test match done");
		// counter write lands on the compare value
		wr(`TMR0_IDX_CMP_A, 8'h40);
		wr(`TMR0_IDX_CMP_B, 8'h90);
		wr(`TMR0_IDX_COUNTER, 8'h00);
		wr(`TMR0_IDX_CTL_B, 8'h01);
		wr(`TMR0_IDX_COUNTER, 8'h40);
		wr(`TMR0_IDX_CTL_B, 8'h00);
		rdc(`TMR0_IDX_FLAGS, 8'h00);
		wr(`TMR0_IDX_COUNTER, 8'hfd);
		wr(`TMR0_IDX_CTL_B, 8'h01);
		repeat (6) @(posedge aclk);
		wr(`TMR0_IDX_CTL_B, 8'h00);
		rdc(`TMR0_IDX_FLAGS, 8'h01);
		wr(`TMR0_IDX_ENABLES, 8'h07);
		chk(irq_overflow, 1'b1, "irq_ovf");
		@(posedge aclk) vector_ack_overflow <= 1'b1;
		@(posedge aclk) vector_ack_overflow <= 1'b0;
		rdc(`TMR0_IDX_FLAGS, 8'h00);
		// ctc: counter clears at compare a, overflow stays clear
		wr(`TMR0_IDX_CTL_A, 8'h02);
		wr(`TMR0_IDX_COUNTER, 8'h3e);
		wr(`TMR0_IDX_CTL_B, 8'h01);
		repeat (6) @(posedge aclk);
		wr(`TMR0_IDX_CTL_B, 8'h00);
		rdc(`TMR0_IDX_FLAGS, 8'h02);
		chk(irq_match_a, 1'b1, "irq_a");
		rd(`TMR0_IDX_COUNTER);
		chk(d < 8'h10, 1'b1, "ctc");
		v = d;
		wr(`TMR0_IDX_CTL_B, 8'h80);
		rdc(`TMR0_IDX_COUNTER, v);
		rdc(`TMR0_IDX_FLAGS, 8'h02);
		wr(`TMR0_IDX_FLAGS, 8'h02);
		rdc(`TMR0_IDX_FLAGS, 8'h00);
		chk(irq, 1'b0, "irq");
		// phase correct: turns at max, no overflow there
		wr(`TMR0_IDX_CTL_A, 8'h01);
		wr(`TMR0_IDX_COUNTER, 8'hfd);
		wr(`TMR0_IDX_CTL_B, 8'h01);
		repeat (6) @(posedge aclk);
		wr(`TMR0_IDX_CTL_B, 8'h00);
		rdc(`TMR0_IDX_FLAGS, 8'h00);
		rd(`TMR0_IDX_COUNTER);
		chk(d > 8'hf0 && d < 8'hff, 1'b1, "phase");
		$display("test modes done");
		cpu_global_irq_enable <= 1'b0;
		$display("test overflow done");
		wr(`TMR0_IDX_CTL_A, 8'hc0);
		wr(`TMR0_IDX_CTL_B, 8'h80);
		chk(wave_out_a, 1'b1, "wave_a");
		chk({wave_oe_a, wave_oe_b}, 2'b10, "wave_oe");
		rdc(`TMR0_IDX_CTL_B, 8'h00);
		rdc(`TMR0_IDX_FLAGS, 8'h00);
		wr(`TMR0_IDX_CTL_A, 8'h83);
		wr(`TMR0_IDX_CTL_B, 8'h80);
		chk(wave_out_a, 1'b1, "wave_a");
		wr(`TMR0_IDX_CTL_A, 8'h80);
		wr(`TMR0_IDX_CTL_B, 8'h80);
		chk(wave_out_a, 1'b0, "wave_a");
		wr(`TMR0_IDX_CTL_A, 8'h10);
		wr(`TMR0_IDX_CTL_B, 8'h40);
		chk(wave_out_b, 1'b1, "wave_b");
		chk({wave_oe_a, wave_oe_b}, 2'b01, "wave_oe");
		wr(`TMR0_IDX_CTL_B, 8'h40);
		chk(wave_out_b, 1'b0, "wave_b");
		$display("test force done");
		wr(`TMR0_IDX_CTL_A, 8'h00);
		wr(`TMR0_IDX_COUNTER, 8'h00);
		wr(`TMR0_IDX_CTL_B, {5'h00, `TMR0_CS_EXT_RISE});
		pins(3);
		rdc(`TMR0_IDX_COUNTER, 8'h03);
		wr(`TMR0_IDX_CTL_B, {5'h00, `TMR0_CS_EXT_FALL});
		pins(2);
		rdc(`TMR0_IDX_COUNTER, 8'h05);
		// prescaler phase is free running, so one tick of slack
		for (k = 2; k <= 5; k = k + 1) begin
			wr(`TMR0_IDX_COUNTER, 8'h00);
			wr(`TMR0_IDX_CTL_B, k[7:0]);
			repeat (divf(k) * 10) @(posedge aclk);
			wr(`TMR0_IDX_CTL_B, 8'h00);
			rd(`TMR0_IDX_COUNTER);
			chk(d == 8'd10 || d == 8'd11, 1'b1, "ticks");
		end
		$display("test clocks done");
		repeat (4) begin
			v = $urandom;
			wr(`TMR0_IDX_CMP_B, v);
			rdc(`TMR0_IDX_CMP_B, v);
		end
		// byte lane 0 disabled: write must not land
		s_axi_wstrb <= 4'he;
		wr(`TMR0_IDX_CMP_B, ~v);
		s_axi_wstrb <= 4'hf;
		rdc(`TMR0_IDX_CMP_B, v);
		$display("test random done");
		test_done;
	end
endmodule

bind tmr0_core tmr0_chk u_chk (.*);
